// ===== design/spmc_ctrl.sv
/*
 * Power-mode state machine, comms window control, command bits and
 * reference-channel delta registers of the sensing controller.
 * Assumes the front end pulses sample_done at each sample boundary and
 * pulses event_in bits as events are detected.
 */
// Behaviour
// - Subtract reference delta from assigned channel average
// - Reference delta is reference delta times weight
// - Reference delta reads zero when unassigned
// - Oscillator bit: clear fast clock, set slow
// - Auto switching without wake-only: full and reduced
// - Wake-only enable adds reduced to wake-only step
// - Wake-only mode senses wake channel, others slowly
// - Auto switching steps down after idle window
// - Manual mode field selects full, reduced, wake, halt
// - Slow refresh every 2 to 255 wake samples
// - Streaming: window after every sample on ready
// - Event mode: window only on unmasked event
// - Event windows repeat until flags read
// - Retune command pulses the tuning request for one cycle
// - Soft reset restores every register default except the reference deltas
// - Acknowledge command clears reset indication flag
// - Comms-tuning bit allows streaming during tuning
// - Advanced bit: streaming in full, events otherwise
// - Exit bit ends current comms window
// - Reduced mode samples all channels, fixed period
// - Masked events set no flag, no window
// - Flags stay set until flag register read
module spmc_ctrl
   import spmc_pkg::*;
(
   input  wire logic        clk_sys,       // System clock, 100 MHz
   input  wire logic        rst,           // Asynchronous reset, active high
   input  wire logic        scl_in,        // Serial clock pin level
   input  wire logic        sda_in,        // Serial data pin level
   output logic             sda_out,       // Serial data drive value
   output logic             sda_oe,        // Serial data drive enable
   output logic             ready_n,       // Ready line, low while window open
   input  wire logic        sample_done,   // Sample boundary pulse
   input  wire logic [7:0]  event_in,      // Event type pulses
   input  wire logic        tuning_busy,   // Tuning procedure running
   input  wire logic [7:0]  idle_samples,  // Idle samples before step down
   input  spmc_ref_s [4:0]  ref_in,        // Reference inputs per channel
   output logic [4:0][15:0] lta_adj,       // Averages after reference removal
   output logic             osc_slow,      // Main oscillator slow select
   output spmc_pmode_e      pmode,         // Current power mode
   output logic             sense_wake,    // Sense wake channel this sample
   output logic             sense_all,     // Sense all active channels
   output logic             retune_req,    // Tuning request pulse
   output logic             comm_window    // Sensing paused for comms
);

   // ==========================================================
   // Refresh period of the wake-only mode
   function automatic logic [7:0] upd_period(input logic [2:0] code);
      upd_period = (code == 3'h7) ? 8'hFF : 8'(9'h002 << code);
   endfunction

   // Scaled reference delta
   function automatic logic [15:0] ref_scale(input logic [15:0] d, input logic [7:0] w);
      logic [23:0] p;
      p = d * w;
      ref_scale = p[REF_WEIGHT_SHIFT +: 16];
   endfunction

   spmc_req_s        req;
   logic [15:0]      rd_data;
   logic             bus_stop;
   logic [15:0]      pset_r, sys_r;
   logic [7:0]       flags_r;
   logic             show_reset_r, srst_r, win_r, refresh_r;
   logic [7:0]       idle_r, ulp_r;
   logic [4:0][15:0] ref_r, lta_r;
   spmc_pmode_e      st_r, st_nxt;

   // ==========================================================
   // Serial bus slave
   spmc_serial_slave u_slave (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .scl_in   (scl_in),
      .sda_in   (sda_in),
      .sda_out  (sda_out),
      .sda_oe   (sda_oe),
      .req      (req),
      .rd_data  (rd_data),
      .bus_stop (bus_stop)
   );

   // ==========================================================
   // Write decode and command pulses
   wire wr_pset  = req.wr & (req.addr == OFS_POWER_CMD);
   wire wr_sys   = req.wr & (req.addr == OFS_SYS_SETTINGS);
   wire cmd_srst = wr_pset & req.wdata[POS_SOFT_RESET];
   wire cmd_ack  = wr_pset & req.wdata[POS_ACK_RESET];
   wire cmd_exit = wr_pset & req.wdata[POS_EXIT_WINDOW];
   wire cmd_tune = wr_pset & req.wdata[POS_RETUNE];
   wire rd_flags = req.rd & (req.addr == OFS_EVENT_FLAGS);

   // Settings fields
   wire       auto_on   = ~pset_r[POS_AUTO_DISABLE];
   wire       wake_en   = pset_r[POS_WAKE_ONLY_EN];
   wire [1:0] mode_sel  = pset_r[POS_MODE_HI:POS_MODE_LO];
   wire [2:0] upd_code  = pset_r[POS_UPD_HI:POS_UPD_LO];
   wire       ev_mode   = pset_r[POS_EVENT_MODE];
   wire       tune_com  = pset_r[POS_COMMS_TUNING];
   wire       strm_full = pset_r[POS_STREAM_FULL];
   wire [7:0] ev_mask   = sys_r[7:0];

   // ==========================================================
   // Register read mux
   always_comb begin
      case (req.addr)
         OFS_EVENT_FLAGS:  rd_data = {show_reset_r, 7'h00, flags_r};
         OFS_REF_WAKE:     rd_data = ref_r[0];
         OFS_REF_PAD:      rd_data = ref_r[1];
         OFS_REF_GEN0:     rd_data = ref_r[2];
         OFS_REF_GEN1:     rd_data = ref_r[3];
         OFS_REF_GEN2:     rd_data = ref_r[4];
         OFS_POWER_CMD:    rd_data = pset_r;
         OFS_SYS_SETTINGS: rd_data = sys_r;
         default:          rd_data = 16'h0000;
      endcase
   end

   // ==========================================================
   // Settings registers; command bits are not stored
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pset_r <= RST_POWER_CMD;
         sys_r  <= RST_SYS;
         srst_r <= 1'b0;
      end else begin
         srst_r <= cmd_srst;
         if (srst_r) begin
            pset_r <= RST_POWER_CMD;
            sys_r  <= RST_SYS;
         end else begin
            if (wr_pset) begin
               pset_r <= req.wdata & ~CMD_BITS_MASK;
            end
            if (wr_sys) begin
               sys_r <= req.wdata;
            end
         end
      end
   end

   // Retune request pulse, cleared the next cycle
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         retune_req <= 1'b0;
      end else begin
         retune_req <= cmd_tune & ~srst_r;
      end
   end

   assign osc_slow = pset_r[POS_OSC_SLOW];

   // ==========================================================
   // Power mode next-state
   wire user_ev  = event_in[POS_EV_PROX] | event_in[POS_EV_TOUCH];
   wire idle_hit = (idle_r >= idle_samples);

   always_comb begin
      st_nxt = st_r;
      if (!auto_on) begin
         case (mode_sel)
            MODE_FULL:    st_nxt = PM_FULL;
            MODE_REDUCED: st_nxt = PM_REDUCED;
            MODE_WAKE:    st_nxt = PM_WAKE;
            default:      st_nxt = PM_HALT;
         endcase
      end else if (user_ev) begin
         st_nxt = PM_FULL;
      end else if (idle_hit) begin
         case (st_r)
            PM_FULL:    st_nxt = PM_REDUCED;
            PM_REDUCED: st_nxt = wake_en ? PM_WAKE : PM_REDUCED;
            PM_WAKE:    st_nxt = wake_en ? PM_WAKE : PM_REDUCED;
            PM_HALT:    st_nxt = PM_FULL;
            default:    st_nxt = PM_FULL;
         endcase
      end
   end

   wire mode_chg = sample_done & (st_nxt != st_r);

   // State register, moves on a sample boundary, or to full on soft reset
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_r <= PM_FULL;
      end else if (srst_r) begin
         st_r <= PM_FULL;
      end else if (sample_done) begin
         st_r <= st_nxt;
      end
   end

   // Idle sample counter for auto stepping
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         idle_r <= 8'h00;
      end else if (srst_r || user_ev || mode_chg) begin
         idle_r <= 8'h00;
      end else if (sample_done && idle_r != 8'hFF) begin
         idle_r <= idle_r + 8'h01;
      end
   end

   // ==========================================================
   // Wake-only slow refresh counter
   wire ulp_last = (ulp_r + 8'h01 >= upd_period(upd_code));

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ulp_r     <= 8'h00;
         refresh_r <= 1'b0;
      end else if (srst_r || st_r != PM_WAKE) begin
         ulp_r     <= 8'h00;
         refresh_r <= 1'b0;
      end else if (sample_done) begin
         refresh_r <= ulp_last & (st_nxt == PM_WAKE);
         ulp_r     <= ulp_last ? 8'h00 : ulp_r + 8'h01;
      end
   end

   // Channel sensing selection
   assign pmode      = st_r;
   assign sense_wake = (st_r != PM_HALT);
   assign sense_all  = (st_r == PM_FULL) | (st_r == PM_REDUCED) | refresh_r;

   // ==========================================================
   // Event flags and reset indication
   wire [7:0] ev_raw = event_in | {mode_chg, 7'h00};
   wire [7:0] ev_new = ev_raw & ~ev_mask;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         flags_r      <= 8'h00;
         show_reset_r <= 1'b1;
      end else if (srst_r) begin
         flags_r      <= 8'h00;
         show_reset_r <= 1'b1;
      end else begin
         flags_r <= (rd_flags ? 8'h00 : flags_r) | ev_new;
         if (cmd_ack) begin
            show_reset_r <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Communication window
   wire stream  = ~ev_mode | (strm_full & st_r == PM_FULL);
   wire blocked = tuning_busy & ~tune_com;
   wire pending = (flags_r != 8'h00) | (ev_new != 8'h00);
   wire open_w  = sample_done & ~blocked & (stream | pending);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         win_r <= 1'b0;
      end else if (srst_r || cmd_exit || bus_stop) begin
         win_r <= 1'b0;
      end else if (open_w) begin
         win_r <= 1'b1;
      end
   end

   assign ready_n     = ~win_r;
   assign comm_window = win_r;

   // ==========================================================
   // Reference deltas and adjusted averages
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ref_r <= '0;
         lta_r <= '0;
      end else begin
         for (int i = 0; i < 5; i++) begin
            if (ref_in[i].assigned) begin
               ref_r[i] <= ref_scale(ref_in[i].delta, ref_in[i].weight);
               lta_r[i] <= ref_in[i].long_term_average - ref_scale(ref_in[i].delta,
                                                     ref_in[i].weight);
            end else begin
               ref_r[i] <= 16'h0000;
               lta_r[i] <= ref_in[i].long_term_average;
            end
         end
      end
   end

   assign lta_adj = lta_r;

endmodule

// ===== design/spmc_pkg.sv
/*
 * Package for the sensor power-mode and comms control block: register
 * offsets, field positions, reset values, state codes and carriers.
 * Assumes a byte-pointer register space reached over a two-wire serial bus.
 */
package spmc_pkg;

   // ==========================================================
   // Register offsets
   localparam logic [7:0] OFS_EVENT_FLAGS   = 8'h02;
   localparam logic [7:0] OFS_REF_WAKE      = 8'h27;
   localparam logic [7:0] OFS_REF_PAD       = 8'h28;
   localparam logic [7:0] OFS_REF_GEN0      = 8'h29;
   localparam logic [7:0] OFS_REF_GEN1      = 8'h2A;
   localparam logic [7:0] OFS_REF_GEN2      = 8'h2B;
   localparam logic [7:0] OFS_POWER_CMD     = 8'h80;
   localparam logic [7:0] OFS_SYS_SETTINGS  = 8'h81;

   // ==========================================================
   // Fields of power_and_command_settings (offset 0 in [15:8])
   localparam int POS_OSC_SLOW      = 15;
   localparam int POS_WAKE_ONLY_EN  = 14;
   localparam int POS_AUTO_DISABLE  = 13;
   localparam int POS_MODE_HI       = 12;
   localparam int POS_MODE_LO       = 11;
   localparam int POS_UPD_HI        = 2 + 8;
   localparam int POS_UPD_LO        = 8;
   localparam int POS_COMMS_TUNING  = 7;
   localparam int POS_EVENT_MODE    = 6;
   localparam int POS_STREAM_FULL   = 5;
   localparam int POS_EXIT_WINDOW   = 4;
   localparam int POS_SOFT_RESET    = 2;
   localparam int POS_RETUNE        = 1;
   localparam int POS_ACK_RESET     = 0;
   localparam logic [15:0] CMD_BITS_MASK = 16'h0017;
   localparam logic [15:0] RST_POWER_CMD = 16'h0000;
   localparam logic [15:0] RST_SYS       = 16'h0000;

   // Event flag layout: reset indication is bit 15, event types in [7:0]
   localparam int POS_SHOW_RESET    = 15;
   localparam int POS_EV_POWER      = 7;
   localparam int POS_EV_PROX       = 0;
   localparam int POS_EV_TOUCH      = 1;

   // Reference weight is a fraction of 256
   localparam int REF_WEIGHT_SHIFT  = 8;

   // Manual mode codes
   localparam logic [1:0] MODE_FULL    = 2'h0;
   localparam logic [1:0] MODE_REDUCED = 2'h1;
   localparam logic [1:0] MODE_WAKE    = 2'h2;
   localparam logic [1:0] MODE_HALT    = 2'h3;

   // Serial bus address of this device
   localparam logic [6:0] DEV_ADDR = 7'h44;

   // ==========================================================
   // Types
   typedef enum logic [3:0] {
      PM_FULL    = 4'h1,
      PM_REDUCED = 4'h2,
      PM_WAKE    = 4'h4,
      PM_HALT    = 4'h8
   } spmc_pmode_e;

   typedef struct packed {
      logic        assigned;            // Channel has a reference channel
      logic [15:0] delta;               // Delta of the assigned reference channel
      logic [7:0]  weight;              // Impact weight, fraction of 256
      logic [15:0] long_term_average;                 // Channel long_term_average
   } spmc_ref_s;

   typedef struct packed {
      logic        wr;                  // Write strobe
      logic        rd;                  // Read fetch strobe
      logic [7:0]  addr;                // Register pointer
      logic [15:0] wdata;               // Offset 0 in [15:8], offset 1 in [7:0]
   } spmc_req_s;

endpackage

// ===== design/spmc_serial_slave.sv
/*
 * Two-wire serial slave: pointer byte, then 16-bit registers as two bytes
 * (offset 0 first), pointer steps after each pair.
 * Assumes scl and sda inputs are synchronous to clk_sys.
 */
module spmc_serial_slave
   import spmc_pkg::*;
(
   input  wire logic        clk_sys,    // System clock
   input  wire logic        rst,        // Asynchronous reset
   input  wire logic        scl_in,     // Serial clock level
   input  wire logic        sda_in,     // Serial data level
   output logic             sda_out,    // Serial data drive value
   output logic             sda_oe,     // Serial data drive enable
   output spmc_req_s        req,        // Register request
   input  wire logic [15:0] rd_data,    // Register read data for req.addr
   output logic             bus_stop    // Stop condition seen
);

   typedef enum logic [4:0] {
      SS_IDLE = 5'h01,
      SS_ADDR = 5'h02,
      SS_PTR  = 5'h04,
      SS_WR   = 5'h08,
      SS_RD   = 5'h10
   } spmc_ss_e;

   spmc_ss_e    st_r;
   logic        scl_q_r, sda_q_r, byte_r, mack_r, oe_r, wr_r;
   logic [3:0]  bit_r;
   logic [7:0]  sh_r, tx_r, ptr_r, hold_r;
   logic [15:0] rbuf_r, wdat_r;

   // ==========================================================
   // Bus condition decode
   wire scl_rise = scl_in & ~scl_q_r;
   wire scl_fall = ~scl_in & scl_q_r;
   wire start_c  = scl_in & scl_q_r & sda_q_r & ~sda_in;
   wire stop_c   = scl_in & scl_q_r & ~sda_q_r & sda_in;
   wire last_bit = scl_fall & (bit_r == 4'h7);
   wire ack_end  = scl_fall & (bit_r == 4'h8);
   wire fetch    = ack_end & (st_r == SS_RD) & mack_r & ~byte_r;

   assign sda_out  = tx_r[7];
   assign sda_oe   = oe_r;
   assign bus_stop = stop_c;
   assign req      = '{wr: wr_r, rd: fetch, addr: ptr_r, wdata: wdat_r};

   // Line history
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         scl_q_r <= 1'b1;
         sda_q_r <= 1'b1;
      end else begin
         scl_q_r <= scl_in;
         sda_q_r <= sda_in;
      end
   end

   // Byte engine
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_r   <= SS_IDLE;
         bit_r  <= 4'h0;
         sh_r   <= 8'h00;
         tx_r   <= 8'hFF;
         ptr_r  <= 8'h00;
         hold_r <= 8'h00;
         rbuf_r <= 16'h0000;
         wdat_r <= 16'h0000;
         byte_r <= 1'b0;
         mack_r <= 1'b0;
         oe_r   <= 1'b0;
         wr_r   <= 1'b0;
      end else begin
         wr_r <= 1'b0;
         if (start_c) begin
            st_r  <= SS_ADDR;
            bit_r <= 4'hF;  // Start's scl fall wraps it to 0
            oe_r  <= 1'b0;
         end else if (stop_c) begin
            st_r <= SS_IDLE;
            oe_r <= 1'b0;
         end else if (st_r != SS_IDLE) begin
            if (scl_rise && bit_r < 4'h8) begin
               sh_r <= {sh_r[6:0], sda_in};
            end
            if (scl_rise && bit_r == 4'h8 && st_r == SS_RD) begin
               mack_r <= ~sda_in;
            end
            if (last_bit) begin
               bit_r <= 4'h8;
               tx_r  <= 8'h00;
               oe_r  <= (st_r != SS_RD);
               case (st_r)
                  SS_ADDR: begin
                     if (sh_r[7:1] != DEV_ADDR) begin
                        st_r <= SS_IDLE;
                        oe_r <= 1'b0;
                     end else if (sh_r[0]) begin
                        st_r   <= SS_RD;
                        byte_r <= 1'b0;
                        mack_r <= 1'b1;
                     end else begin
                        st_r <= SS_PTR;
                     end
                  end
                  SS_PTR: begin
                     ptr_r  <= sh_r;
                     byte_r <= 1'b0;
                     st_r   <= SS_WR;
                  end
                  SS_WR: begin
                     byte_r <= ~byte_r;
                     hold_r <= sh_r;
                     if (byte_r) begin
                        wdat_r <= {hold_r, sh_r};
                        wr_r   <= 1'b1;
                     end
                  end
                  SS_RD: begin
                     byte_r <= ~byte_r;
                     tx_r   <= 8'hFF;
                  end
                  default: st_r <= SS_IDLE;
               endcase
            end else if (ack_end) begin
               bit_r <= 4'h0;
               oe_r  <= 1'b0;
               if (st_r == SS_RD) begin
                  oe_r <= mack_r;
                  if (!mack_r) begin
                     st_r <= SS_IDLE;
                  end else if (!byte_r) begin
                     tx_r   <= rd_data[15:8];
                     rbuf_r <= rd_data;
                  end else begin
                     tx_r <= rbuf_r[7:0];
                  end
               end
            end else if (scl_fall) begin
               bit_r <= bit_r + 4'h1;
               tx_r  <= {tx_r[6:0], 1'b1};
            end
            // Pointer steps once a full register has moved
            if (wr_r || (last_bit && st_r == SS_RD && byte_r)) begin
               ptr_r <= ptr_r + 8'h01;
            end
         end
      end
   end

endmodule

// ===== verif/spmc_ctrl_bench.sv
/* Bench for spmc_ctrl: reset and command cases, reference rows, then hand-written cases.
   Assumes spmc_host as master and spmc_ctrl_props bound below. */
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin num_errors++; \
   $display("ERROR %0t got %h exp %h", $time, a, e); end end
module spmc_ctrl_bench
   import spmc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // ==========
   // Signals; rows beside expected deltas
   logic clk_sys, rst, sample_done, tuning_busy, scl, host_low, sda_out, sda_oe;
   logic ready_n, osc_slow, sense_wake, sense_all, retune_req, comm_window;
   logic [7:0] event_in, idle_samples;
   logic [15:0] rd;
   logic [4:0][15:0] lta_adj;
   spmc_ref_s [4:0] ref_in;
   spmc_pmode_e pmode;
   int num_errors = 0;
   int n_checks = 0;
   int retunes = 0;
   int hits;
   wire sda_line = !((sda_oe && !sda_out) || host_low);  // Pull-up
   spmc_ref_s rows [4] = '{'{1'b1, 16'h0100, 8'h80, 16'h1000},
      '{1'b1, 16'h1234, 8'hFF, 16'h8000}, '{1'b0, 16'hFFFF, 8'hFF, 16'h0042},
      '{1'b1, 16'h0010, 8'h00, 16'h0005}};
   logic [15:0] dl [4] = '{16'h0080, 16'h1221, 16'h0000, 16'h0000};
   // ==========
   // Design, host, clock
   spmc_ctrl spmc_ctrl_inst (.clk_sys(clk_sys), .rst(rst), .scl_in(scl),
      .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .ready_n(ready_n),
      .sample_done(sample_done), .event_in(event_in), .tuning_busy(tuning_busy),
      .idle_samples(idle_samples), .ref_in(ref_in), .lta_adj(lta_adj),
      .osc_slow(osc_slow), .pmode(pmode), .sense_wake(sense_wake),
      .sense_all(sense_all), .retune_req(retune_req), .comm_window(comm_window));
   spmc_host spmc_host_inst (.scl(scl), .sda_low(host_low), .sda(sda_line));
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) if (retune_req === 1'b1) retunes++;
   // Bus and sample helpers
   task automatic put(input logic [7:0] a, input logic [15:0] d);
      spmc_host_inst.wr(a, d);
   endtask
   task automatic get(input logic [7:0] a);
      spmc_host_inst.rd(a, rd);
   endtask
   task automatic samp(input logic [7:0] ev);
      sample_done = 1'b1;
      event_in = ev;
      @(posedge clk_sys) #1;
      sample_done = 1'b0;
      event_in = 8'h00;
      repeat (3) @(posedge clk_sys);
      #1;
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #600us;
      num_errors++;
      final_report();
   end
   // ==========
   // Tests
   initial begin
      {rst, sample_done, tuning_busy, event_in, idle_samples, ref_in} = '1;
      {sample_done, tuning_busy, event_in, ref_in} = '0;
      repeat (6) @(posedge clk_sys);
      #1 rst = 1'b0;
      `CHK(osc_slow, 1'b0)
      get(OFS_EVENT_FLAGS);
      `CHK(rd[15], 1'b1)
      put(OFS_POWER_CMD, 16'h0001);
      get(OFS_POWER_CMD);
      `CHK(rd, 16'h0000)
      get(OFS_EVENT_FLAGS);
      `CHK(rd[15], 1'b0)
      put(OFS_POWER_CMD, 16'h0002);
      `CHK(retunes, 1)
      for (int r = 0; r < 4; r++) begin
         ref_in = {5{rows[r]}};
         repeat (2) @(posedge clk_sys);
         #1;
         `CHK(lta_adj[r], rows[r].long_term_average - dl[r])
         get(OFS_REF_WAKE + 8'(r));
         `CHK(rd, dl[r])
      end
      for (int m = 0; m < 4; m++) begin
         put(OFS_POWER_CMD, 16'h2000 | (16'(m) << 11));
         samp(8'h00);
         `CHK(pmode, spmc_pmode_e'(4'h1 << m))
         `CHK(sense_wake, 1'(m != 3))
      end
      put(OFS_POWER_CMD, 16'hA000);
      `CHK(osc_slow, 1'b1)
      put(OFS_POWER_CMD, 16'h0004);
      get(OFS_POWER_CMD);
      `CHK({rd, osc_slow, pmode}, {17'h0, PM_FULL})
      $display("test registers done");
      samp(8'h00);
      `CHK(comm_window, 1'b1)
      put(OFS_POWER_CMD, 16'h2040);
      get(OFS_EVENT_FLAGS);
      samp(8'h00);
      `CHK(comm_window, 1'b0)
      samp(8'h01);
      `CHK(comm_window, 1'b1)
      put(OFS_POWER_CMD, 16'h2050);
      `CHK(comm_window, 1'b0)
      samp(8'h00);
      `CHK(comm_window, 1'b1)
      get(OFS_EVENT_FLAGS);
      `CHK(rd[0], 1'b1)
      samp(8'h00);
      `CHK(comm_window, 1'b0)
      put(OFS_SYS_SETTINGS, 16'h0001);
      samp(8'h01);
      `CHK(comm_window, 1'b0)
      tuning_busy = 1'b1;
      put(OFS_POWER_CMD, 16'h20E0);
      samp(8'h00);
      `CHK(comm_window, 1'b1)
      put(OFS_POWER_CMD, 16'h2060);
      samp(8'h00);
      `CHK(comm_window, 1'b0)
      $display("test windows done");
      put(OFS_POWER_CMD, 16'h0000);
      idle_samples = 8'h02;
      repeat (8) samp(8'h00);
      `CHK(pmode, PM_REDUCED)
      put(OFS_POWER_CMD, 16'h4000);
      repeat (8) samp(8'h00);
      `CHK(pmode, PM_WAKE)
      for (int k = 0; k < 2; k++) begin
         put(OFS_POWER_CMD, 16'h4000 | (16'(k) << 8));
         hits = 0;
         repeat (8) begin
            samp(8'h00);
            hits += int'(sense_all === 1'b1);
         end
         `CHK(hits, 4 >> k)
      end
      samp(8'h02);
      `CHK(pmode, PM_FULL)
      `CHK(spmc_host_inst.nacks, 0)
      $display("test modes done");
      final_report();
   end
endmodule
bind spmc_ctrl spmc_ctrl_props spmc_ctrl_props_inst (.clk_sys(clk_sys), .rst(rst),
   .sample_done(sample_done), .ref_in(ref_in), .lta_adj(lta_adj), .pmode(pmode),
   .sense_wake(sense_wake), .sense_all(sense_all), .retune_req(retune_req),
   .ready_n(ready_n));

// ===== verif/spmc_ctrl_props.sv
/* Checker for the spmc_ctrl ports.
   Assumes one clock and rst active high. */
module spmc_ctrl_props
   import spmc_pkg::*;
(
   input wire logic             clk_sys,     // Clock
   input wire logic             rst,         // Reset
   input wire logic             sample_done, // Sample edge
   input spmc_ref_s [4:0]       ref_in,      // References
   input wire logic [4:0][15:0] lta_adj,     // Averages
   input spmc_pmode_e           pmode,       // Mode
   input wire logic             sense_wake,  // Wake sensed
   input wire logic             sense_all,   // All sensed
   input wire logic             retune_req,  // Tune pulse
   input wire logic             ready_n      // Ready line
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========
   // Properties
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence s_quiet; !sample_done; endsequence
   property p_ref_sub; ref_in[0].assigned |=> lta_adj[0] == $past(ref_in[0].long_term_average)
      - 16'((24'($past(ref_in[0].delta)) * $past(ref_in[0].weight)) >> 8); endproperty
   property p_ref_none; !ref_in[1].assigned |=> lta_adj[1] == $past(ref_in[1].long_term_average); endproperty
   property p_edge; s_quiet |=> $stable(pmode) || pmode == PM_FULL; endproperty
   property p_halt; pmode == PM_HALT |-> !sense_wake && !sense_all; endproperty
   property p_wake; pmode == PM_WAKE |-> sense_wake; endproperty
   property p_full; pmode inside {PM_FULL, PM_REDUCED} |-> sense_all && sense_wake; endproperty
   property p_open; $fell(ready_n) |-> $past(sample_done); endproperty
   property p_retune; retune_req |=> !retune_req; endproperty
   // Assertions
   a_ref_sub: assert property (p_ref_sub) else $error("bad average");
   a_ref_none: assert property (p_ref_none) else $error("bad plain average");
   a_edge: assert property (p_edge) else $error("mode moved off boundary");
   a_halt: assert property (p_halt) else $error("sensing in halt");
   a_wake: assert property (p_wake) else $error("wake channel idle");
   a_full: assert property (p_full) else $error("channels skipped");
   a_open: assert property (p_open) else $error("window off boundary");
   a_retune: assert property (p_retune) else $error("tune pulse long");
endmodule

// ===== verif/spmc_host.sv
/* Host model: serial master for 16-bit register access.
   Assumes the bench resolves the data line with a pull-up. */
module spmc_host
   import spmc_pkg::*;
(
   output logic      scl,     // Serial clock
   output logic      sda_low, // Pull data low
   input  wire logic sda      // Data line level
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int HALF = 50;  // Five clocks per half bit
   int         nacks = 0;     // Missing acknowledges
   logic [8:0] rx;            // Last nine bits seen
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // Start, also used as repeated start
   task automatic start();
      sda_low = 1'b0;
      #HALF scl = 1'b1;
      #HALF sda_low = 1'b1;
      #HALF scl = 1'b0;
   endtask
   task automatic stop();
      sda_low = 1'b1;
      #HALF scl = 1'b1;
      #HALF sda_low = 1'b0;
      #HALF;
   endtask
   // Eight bits and the acknowledge slot
   task automatic byte9(input logic [8:0] tx, input logic chk);
      for (int i = 8; i >= 0; i--) begin
         sda_low = !tx[i];
         #HALF scl = 1'b1;
         rx[i] = sda;
         #HALF scl = 1'b0;
      end
      if (chk && rx[0] !== 1'b0)
         nacks++;
   endtask
   task automatic wr(input logic [7:0] p, input logic [15:0] d);
      start();
      byte9({DEV_ADDR, 2'b01}, 1'b1);
      byte9({p, 1'b1}, 1'b1);
      byte9({d[15:8], 1'b1}, 1'b1);
      byte9({d[7:0], 1'b1}, 1'b1);
      stop();
   endtask
   // Pointer write, repeated start, two bytes read
   task automatic rd(input logic [7:0] p, output logic [15:0] d);
      start();
      byte9({DEV_ADDR, 2'b01}, 1'b1);
      byte9({p, 1'b1}, 1'b1);
      start();
      byte9({DEV_ADDR, 2'b11}, 1'b1);
      byte9(9'h1FE, 1'b0);
      d[15:8] = rx[8:1];
      byte9(9'h1FF, 1'b0);
      d[7:0] = rx[8:1];
      stop();
   endtask
endmodule
